/* core/spi_reg_slave.sv */
// Four-wire serial slave giving an external master write and read access to a 119-byte register map.
// Assumes the master keeps the serial clock low while chip select is high, and that the address
// select pin is a static strap that only changes while no frame is in progress.

`timescale 1ns/1ps
`default_nettype none

module spi_reg_slave (
  input  wire logic       ref_clk_i,         // System clock, 100 MHz.
  input  wire logic       nrst_i,            // Asynchronous reset, active low.
  input  wire logic       sclk_i,            // Serial clock from the master.
  input  wire logic       cs_n_i,            // Chip select, active low.
  input  wire logic       serial_in_line_i,  // Serial data from the master.
  input  wire logic       addr_sel_i,        // Slave address select strap.
  output logic            serial_out_line_o, // Serial data to the master.
  output logic            serial_out_oe_o,   // High while the serial output is driven.
  output logic            wr_strobe_o,       // One-cycle pulse per register written.
  output logic [6:0]      wr_addr_o,         // Address of the register just written.
  output logic [7:0]      wr_data_o,         // Value just written.
  output logic            frame_busy_o,      // Chip select low, synchronised.
  output logic            frame_done_o       // One-cycle pulse when a frame ends.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Step the register pointer, rolling over past the last register.
  function automatic logic [6:0] step_ptr(input logic [6:0] ptr);
    if (ptr >= spi_regs_pkg::REG_LAST) begin
      step_ptr = spi_regs_pkg::REG_FIRST;
    end else begin
      step_ptr = ptr + 7'h01;
    end
  endfunction

  // Compare the seven address bits of a first byte with this device's address.
  function automatic logic addr_hit(input logic [7:0] first_byte, input logic sel);
    logic [7:0] mine;
    mine     = sel ? spi_regs_pkg::SLAVE_ADDR_HIGH : spi_regs_pkg::SLAVE_ADDR_LOW;
    addr_hit = (first_byte[7:1] == mine[7:1]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: frame reset and receive state.

  // The frame logic is held in its idle state while deselected or under reset, so every
  // frame begins with a cleared shift register and no half-finished byte survives.
  logic frame_rst_n;
  assign frame_rst_n = nrst_i & ~cs_n_i;

  logic [7:0] mem [0:spi_regs_pkg::REG_COUNT-1];
  logic [6:0] rx_shift;
  logic [2:0] bit_pos;
  logic [1:0] byte_idx;
  logic       matched;
  logic       dir;
  logic       auto_inc;
  logic [6:0] ptr;
  logic [7:0] next_byte;
  logic       byte_end;
  logic       sel_strap;

  assign next_byte = {rx_shift, serial_in_line_i};
  assign byte_end  = (bit_pos == spi_regs_pkg::BIT_LAST);

  always_ff @(posedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rx_shift <= 7'h00;
      bit_pos  <= spi_regs_pkg::BIT_FIRST;
    end else begin
      rx_shift <= next_byte[6:0];
      bit_pos  <= bit_pos + 3'h1;
    end
  end

  // Byte index saturates at the data stage; later bytes are all data bytes.
  always_ff @(posedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      byte_idx <= spi_regs_pkg::BYTE_SLAVE;
    end else if (byte_end && byte_idx != spi_regs_pkg::BYTE_DATA) begin
      byte_idx <= byte_idx + 2'h1;
    end
  end

  always_ff @(posedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      matched <= 1'b0;
      dir     <= spi_regs_pkg::DIR_WRITE;
    end else if (byte_end && byte_idx == spi_regs_pkg::BYTE_SLAVE) begin
      matched <= addr_hit(next_byte, sel_strap);
      dir     <= next_byte[spi_regs_pkg::DIR_BIT];
    end
  end

  // Pointer loads from the register address byte and, when its auto-increment bit is set, moves on after each data byte.
  always_ff @(posedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      auto_inc <= 1'b0;
      ptr      <= spi_regs_pkg::REG_FIRST;
    end else if (byte_end && byte_idx == spi_regs_pkg::BYTE_REG) begin
      auto_inc <= next_byte[spi_regs_pkg::AUTO_BIT];
      ptr      <= next_byte[6:0];
    end else if (byte_end && byte_idx == spi_regs_pkg::BYTE_DATA && auto_inc) begin
      ptr      <= step_ptr(ptr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: register map.

  // A register is written only when a whole data byte has arrived, so short frames and
  // trailing partial bytes never reach the map. The map is reset by the reset pin only.
  logic       wr_fire;
  logic       wr_toggle;
  logic [6:0] wr_addr_hold;
  logic [7:0] wr_data_hold;

  assign wr_fire = byte_end && byte_idx == spi_regs_pkg::BYTE_DATA && matched
                   && dir == spi_regs_pkg::DIR_WRITE && ptr <= spi_regs_pkg::REG_LAST;

  always_ff @(posedge sclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < spi_regs_pkg::REG_COUNT; i++) begin
        mem[i] <= spi_regs_pkg::REG_RESET;
      end
    end else if (wr_fire && !cs_n_i) begin
      mem[ptr] <= next_byte;
    end
  end

  // Write notice for the system side: data is held until the next write, which is at least
  // eight serial clocks later, far longer than the toggle takes to cross.
  always_ff @(posedge sclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_toggle    <= 1'b0;
      wr_addr_hold <= spi_regs_pkg::REG_FIRST;
      wr_data_hold <= spi_regs_pkg::REG_RESET;
    end else if (wr_fire && !cs_n_i) begin
      wr_toggle    <= ~wr_toggle;
      wr_addr_hold <= ptr;
      wr_data_hold <= next_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: read output on falling edges.

  logic [7:0] tx_shift;
  logic       rd_load;
  logic [7:0] rd_value;

  // The load happens on the falling edge that follows each completed byte from the register
  // byte on, so the first data bit appears before the first rising edge of the first data byte.
  assign rd_load  = (bit_pos == spi_regs_pkg::BIT_FIRST) && (byte_idx == spi_regs_pkg::BYTE_DATA);
  assign rd_value = (ptr <= spi_regs_pkg::REG_LAST) ? mem[ptr] : spi_regs_pkg::REG_RESET;

  always_ff @(negedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      tx_shift <= 8'h00;
    end else if (rd_load) begin
      tx_shift <= rd_value;
    end else begin
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  assign serial_out_line_o = tx_shift[spi_regs_pkg::MSB_BIT];
  // Only a matched read drives the line, so two devices on one select never collide.
  assign serial_out_oe_o   = ~cs_n_i & matched & (dir == spi_regs_pkg::DIR_READ)
                             & (byte_idx == spi_regs_pkg::BYTE_DATA);

  ////////////////////////////////////////////////////////////////////////////////
  // System domain: synchronisers.

  logic       sel_meta;
  logic       cs_meta;
  logic       cs_sync;
  logic       cs_prev;
  logic       tog_meta;
  logic       tog_sync;
  logic       tog_prev;

  // The strap is settled in the system domain; the link logic only reads it at the end of
  // a first byte, when it has been stable for many system clocks.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_meta  <= 1'b0;
      sel_strap <= 1'b0;
    end else begin
      sel_meta  <= addr_sel_i;
      sel_strap <= sel_meta;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      cs_meta <= cs_n_i;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_prev <= 1'b0;
    end else begin
      tog_meta <= wr_toggle;
      tog_sync <= tog_meta;
      tog_prev <= tog_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // System domain: outputs.

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_strobe_o <= 1'b0;
      wr_addr_o   <= spi_regs_pkg::REG_FIRST;
      wr_data_o   <= spi_regs_pkg::REG_RESET;
    end else begin
      wr_strobe_o <= tog_sync ^ tog_prev;
      if (tog_sync ^ tog_prev) begin
        wr_addr_o <= wr_addr_hold;
        wr_data_o <= wr_data_hold;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_busy_o <= 1'b0;
      frame_done_o <= 1'b0;
    end else begin
      frame_busy_o <= ~cs_sync;
      frame_done_o <= cs_sync & ~cs_prev;
    end
  end

endmodule // spi_reg_slave

`default_nettype wire

/* core/spi_regs_pkg.sv */
// Constants shared by the serial register-access slave.
// Assumes a single device with a 119-byte register map behind a four-wire serial slave.
package spi_regs_pkg;

  // Slave addresses, written as the full first byte with the direction bit clear.
  localparam logic [7:0] SLAVE_ADDR_LOW  = 8'h40;
  localparam logic [7:0] SLAVE_ADDR_HIGH = 8'h42;

  // Register map bounds.
  localparam logic [6:0] REG_FIRST = 7'h00;
  localparam logic [6:0] REG_LAST  = 7'h76;
  localparam int         REG_COUNT = 119;

  // Reset value of every register in the map.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions.
  localparam int DIR_BIT   = 0;
  localparam int AUTO_BIT  = 7;
  localparam int MSB_BIT   = 7;

  // Byte indices within a frame.
  localparam logic [1:0] BYTE_SLAVE = 2'h0;
  localparam logic [1:0] BYTE_REG   = 2'h1;
  localparam logic [1:0] BYTE_DATA  = 2'h2;

  // Bit positions of the last and first bits of a byte.
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;

  // Direction encodings.
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ  = 1'b1;

  // Highest serial clock the master may use, and the system clock rate.
  localparam int SCLK_MAX_HZ = 5_000_000;
  localparam int REF_CLK_HZ  = 100_000_000;

  // Least system clock cycles between two byte events at the fastest legal serial clock.
  localparam int BYTE_GAP_CYCLES = (REF_CLK_HZ / SCLK_MAX_HZ) * 8;

endpackage

/* bench/spi_reg_slave_chk.sv */
// Port assertions for the serial register slave.
// Assumes it is bound onto the slave and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module spi_reg_slave_chk (
  input wire logic       ref_clk_i, nrst_i, sclk_i, cs_n_i, serial_in_line_i, addr_sel_i,
  input wire logic       serial_out_line_o, serial_out_oe_o, wr_strobe_o, frame_busy_o, frame_done_o,
  input wire logic [6:0] wr_addr_o,
  input wire logic [7:0] wr_data_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_oe_off_desel: assert property (cs_n_i |-> !serial_out_oe_o) else $error("driven while deselected");
  a_strobe_gap: assert property (wr_strobe_o |=> !wr_strobe_o [*8]) else $error("strobes too close");
  a_reset_quiet: assert property (disable iff (1'b0) !nrst_i |-> !wr_strobe_o && !frame_busy_o)
    else $error("activity in reset");
  a_addr_in_map: assert property (wr_strobe_o |-> wr_addr_o <= 7'h76) else $error("write off map");
  a_wr_hold: assert property (!wr_strobe_o |-> $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("write value moved");
  a_busy_follow: assert property ($fell(cs_n_i) |-> ##[1:5] frame_busy_o) else $error("busy late");
  a_done_after: assert property ($rose(cs_n_i) |-> ##[1:6] frame_done_o) else $error("done missing");
  a_oe_in_frame: assert property ($rose(serial_out_oe_o) |-> frame_busy_o && !cs_n_i)
    else $error("enabled outside frame");
  c_write: cover property (wr_strobe_o);
  c_read: cover property ($rose(serial_out_oe_o));
  c_done: cover property (frame_done_o);
endmodule // spi_reg_slave_chk
bind spi_reg_slave spi_reg_slave_chk chk_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sclk_i(sclk_i),
  .cs_n_i(cs_n_i), .serial_in_line_i(serial_in_line_i), .addr_sel_i(addr_sel_i),
  .serial_out_line_o(serial_out_line_o), .serial_out_oe_o(serial_out_oe_o), .wr_strobe_o(wr_strobe_o),
  .frame_busy_o(frame_busy_o), .frame_done_o(frame_done_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));
`default_nettype wire

/* bench/spi_master_model.sv */
// Serial bus master model; its clock runs only inside frames.
// Assumes the bench calls frame() hierarchically, one frame at a time.
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  output logic      sclk_o,  // Serial clock.
  output logic      cs_n_o,  // Chip select.
  output logic      mosi_o,  // Data to slave.
  input  wire logic miso_i   // Data from slave.
);
  logic [7:0] rx [0:7];
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic frame(input logic [63:0] tx, input int nbits);
    cs_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi_o = tx[63 - i];
      #7.5 sclk_o = 1'b1;
      rx[i / 8][7 - i % 8] = miso_i;
      #7.5 sclk_o = 1'b0;
    end
    // A released data line must not keep showing its last bit.
    mosi_o = ~mosi_o;
    #7.5 cs_n_o = 1'b1;
    #30;
  endtask
endmodule // spi_master_model
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the serial register slave.
// Assumes the master model on the link and a shadow copy of the register map here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        ref_clk_i, nrst_i, addr_sel_i, sclk, cs_n, mosi, miso, oe, stb, busy, done;
  logic        miso_bus;
  logic [6:0]  wa;
  logic [7:0]  wd;
  logic [7:0]  regs [0:118];
  logic [14:0] seen [$];
  logic [14:0] exp_q [$];
  int          mismatches = 0;
  int          cmp_count = 0;
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // An undriven return line shows the inverse of the slave's flop, so a missing enable is caught.
  assign miso_bus = oe ? miso : ~miso;
  spi_master_model mst_u (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_bus));
  spi_reg_slave dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .serial_in_line_i(mosi), .addr_sel_i(addr_sel_i), .serial_out_line_o(miso), .serial_out_oe_o(oe),
    .wr_strobe_o(stb), .wr_addr_o(wa), .wr_data_o(wd), .frame_busy_o(busy), .frame_done_o(done));
  always @(posedge ref_clk_i) if (stb === 1'b1) seen.push_back({wa, wd});
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [6:0] step(input logic [6:0] p, input logic ai);
    if (!ai) return p;
    return (p == spi_regs_pkg::REG_LAST) ? spi_regs_pkg::REG_FIRST : p + 7'h01;
  endfunction
  task automatic check(input logic [14:0] got, input logic [14:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic do_reset;
    nrst_i <= 1'b0;
    repeat (16) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    foreach (regs[i]) regs[i] = spi_regs_pkg::REG_RESET;
    repeat (4) @(posedge ref_clk_i);
  endtask
  // Sends slave byte, register byte, nd data bytes and a few loose bits, then checks.
  task automatic xfer(input logic [7:0] sa, input logic [7:0] ra, input int nd, input int extra);
    logic [63:0] tx;
    logic [6:0]  p;
    logic        hit;
    tx = {sa, ra, 48'({$urandom, $urandom})};
    hit = (sa >> 1) == ((addr_sel_i ? spi_regs_pkg::SLAVE_ADDR_HIGH : spi_regs_pkg::SLAVE_ADDR_LOW) >> 1);
    seen.delete();
    exp_q.delete();
    mst_u.frame(tx, 16 + 8 * nd + extra);
    repeat (8) @(posedge ref_clk_i);
    p = ra[6:0];
    if (hit) for (int k = 0; k < nd; k++) begin
      if (sa[0]) check(15'(mst_u.rx[k + 2]), 15'(p <= spi_regs_pkg::REG_LAST ? regs[p] : 8'h00));
      else if (p <= spi_regs_pkg::REG_LAST) begin
        regs[p] = tx[47 - 8 * k -: 8];
        exp_q.push_back({p, regs[p]});
      end
      p = step(p, ra[7]);
    end
    check(15'(seen.size()), 15'(exp_q.size()));
    foreach (exp_q[i]) if (i < seen.size()) check(seen[i], exp_q[i]);
    $display("Frame %h %h %0d done", sa, ra, nd);
  endtask
  initial begin
    #900000;
    mismatches++;
    finish_test;
  end
  initial begin
    nrst_i = 1'b0;
    addr_sel_i = 1'b0;
    void'($urandom(32'h8a87));
    @(posedge ref_clk_i);
    do_reset;
    xfer(8'h40, 8'h05, 1, 0);
    xfer(8'h41, 8'h05, 1, 0);
    xfer(8'h40, 8'h06, 0, 7);
    xfer(8'h40, 8'hf5, 4, 4);
    xfer(8'h41, 8'hf5, 4, 0);
    xfer(8'h40, 8'h10, 3, 0);
    xfer(8'h41, 8'h10, 2, 0);
    xfer(8'h40, 8'h7f, 1, 0);
    xfer(8'h42, 8'h05, 1, 0);
    @(posedge ref_clk_i);
    addr_sel_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    xfer(8'h41, 8'h05, 1, 0);
    xfer(8'h42, 8'h05, 1, 0);
    xfer(8'h43, 8'h85, 2, 0);
    repeat (24) xfer({6'h20, 1'($urandom), 1'($urandom)}, {1'($urandom), 7'($urandom % 119)},
      int'($urandom % 4), int'($urandom % 8));
    @(posedge ref_clk_i);
    do_reset;
    xfer(8'h43, 8'h85, 3, 0);
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
